// ==== dds_ctrl_pkg.sv ====
package dds_ctrl_pkg;

   // Command word layout
   localparam int WORD_BITS = 16;
   localparam int PHASE_BITS = 12;
   localparam int DEST_HI = 15;
   localparam int DEST_LO = 14;
   localparam int PHASE_SEL_POS = 13;
   localparam logic [1:0] DEST_CONTROL = 2'h0;
   localparam logic [1:0] DEST_FREQ_ZERO = 2'h1;
   localparam logic [1:0] DEST_FREQ_ONE = 2'h2;
   localparam logic [1:0] DEST_PHASE = 2'h3;

   // Control word fields
   localparam int CTL_PHASE_SEL = 10;
   localparam int CTL_PIN_OR_SOFTWARE = 9;
   localparam int CTL_RESET = 8;
   localparam int CTL_CLOCK_DISABLE = 7;
   localparam int CTL_DAC_POWERDOWN = 6;
   localparam int CTL_SQUARE_ENABLE = 5;
   localparam int CTL_COMPARATOR_SEL = 4;
   localparam int CTL_MSB_DIRECT = 3;
   localparam int CTL_MODE = 1;
   localparam logic [15:0] CONTROL_RESET_VALUE = 16'h0000;
   localparam logic [11:0] PHASE_RESET_VALUE = 12'h000;

   // Datapath
   localparam int ACC_BITS = 28;
   localparam int DAC_BITS = 10;
   localparam logic [9:0] DAC_MIDSCALE = 10'h200;
   localparam logic [8:0] SINE_PEAK = 9'h1ff;
   localparam logic [11:0] HALF_TURN = 12'h800;
   localparam int SINE_SHIFT = 11;

   // Cycles from reset release to the first real sample
   localparam logic [2:0] START_LATENCY = 3'h7;

endpackage

// ==== dds_phase_reset_sleep_output_ctrl.sv ====
// Notes on behaviour
// R1: Word with top bits 11 loads a phase register from bits 11..0.
// R2: Bit 13 clear loads phase offset zero, set loads phase offset one.
// R3: Reset clears accumulator and output to midscale, keeps all registers.
// R4: Select bit low: control reset bit governs; high: reset pin governs.
// R5: First real sample reaches the DAC seven master cycles after release.
// R6: Reset pin assertion acts at once; release is sampled on the clock.
// R7: Host applies reset after power-up before trusting the output.
// R8: Select bit high: sleep pin alone powers down DAC only.
// R9: Select bit low: clock-disable and DAC power-down bits act independently.
// R10: Disabled clock freezes accumulator and DAC output; clearing bit resumes.
// R11: Writes and register selection still work while the clock is disabled.
// R12: Sleep pin assertion acts at once; release is sampled on the clock.
// R13: Square output pin driven only while its enable bit is one.
// R14: Source bit one routes comparator, zero routes DAC data MSB.
// R15: Direct bit one gives MSB as is, zero gives MSB halved.
// R16: Host keeps mode zero with square output and avoids comparator-halved.
// R17: Mode zero uses sine lookup; mode one sends 10-bit triangle.
// R18: Host keeps sleep pin and power-down bit low when using analog out.
// R19: Host holds frame strobe low for exactly sixteen bits per word.
// R20: Serial bits captured MSB first on the serial clock falling edge.
// R21: Selected phase offset added to accumulator before amplitude conversion.
// R22: Top bits 00 control word, 01 and 10 frequency registers.
// R23: Phase register updates only after a complete sixteen-bit word.
module dds_phase_reset_sleep_output_ctrl #(
   parameter int SYNC_STAGES = 2
) (
   // Master clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Serial link
   input wire logic sclk,
   input wire logic sdata,
   input wire logic word_frame_strobe_n,
   // Pins
   input wire logic reset_pin,
   input wire logic sleep_pin,
   input wire logic phase_select_pin,
   input wire logic comparator_in,
   // Frequency tuning word of the selected frequency register
   input wire logic [27:0] freq_word,
   // Frequency register loads, handled outside
   output logic freq_load,
   output logic freq_load_one,
   output logic [13:0] freq_load_data,
   // Analog side
   output logic [9:0] dac_data,
   output logic dac_powerdown,
   output logic core_clock_halted,
   // Square output pin
   output logic square_out,
   output logic square_out_oe
);

   localparam int WB = dds_ctrl_pkg::WORD_BITS;
   localparam int PB = dds_ctrl_pkg::PHASE_BITS;
   localparam int AB = dds_ctrl_pkg::ACC_BITS;
   localparam int DB = dds_ctrl_pkg::DAC_BITS;

   // Coarse sine: parabola per half turn, standing in for the lookup ROM
   function automatic logic [9:0] sine_amp(input logic [11:0] ph);
      logic [10:0] p;
      logic [22:0] prod;
      logic [8:0] s;
      p = ph[10:0];
      prod = 23'(p) * 23'(dds_ctrl_pkg::HALF_TURN - 12'(p));
      s = (prod[22:11] > 12'(dds_ctrl_pkg::SINE_PEAK)) ? dds_ctrl_pkg::SINE_PEAK : prod[19:11];
      sine_amp = ph[11] ? dds_ctrl_pkg::DAC_MIDSCALE - 10'(s) : dds_ctrl_pkg::DAC_MIDSCALE + 10'(s);
   endfunction

   function automatic logic [9:0] triangle_amp(input logic [11:0] ph);
      triangle_amp = ph[11] ? ~ph[10:1] : ph[10:1];
   endfunction

   // ---------------- Link domain (serial clock) ----------------
   logic [WB-1:0] shift;
   logic [WB-1:0] word_hold;
   logic [3:0] bit_count;
   logic word_toggle;
   wire [WB-1:0] next_shift = {shift[WB-2:0], sdata};

   // Frame strobe high clears the count, so a short frame cannot misalign the next
   always_ff @(negedge sclk or posedge word_frame_strobe_n) begin
      if (word_frame_strobe_n) begin
         bit_count <= 4'h0;
      end else begin
         bit_count <= bit_count + 4'h1; // see R20
      end
   end

   always_ff @(negedge sclk) begin
      if (!word_frame_strobe_n) begin
         shift <= next_shift; // see R20
      end
   end

   // Whole word handed over at once; held stable until the next word ends
   always_ff @(negedge sclk or posedge srst) begin
      if (srst) begin
         word_toggle <= 1'b0;
      end else if (!word_frame_strobe_n && bit_count == 4'hf) begin
         word_toggle <= ~word_toggle; // see R23
      end
   end

   always_ff @(negedge sclk) begin
      if (!word_frame_strobe_n && bit_count == 4'hf) begin
         word_hold <= next_shift; // see R23
      end
   end

   // ---------------- Crossings into the master domain ----------------
   logic [SYNC_STAGES:0] tog_sync;
   logic [SYNC_STAGES-1:0] reset_sync;
   logic [SYNC_STAGES-1:0] sleep_sync;
   logic [SYNC_STAGES-1:0] psel_sync;
   logic [SYNC_STAGES-1:0] comp_sync;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tog_sync <= '0;
         reset_sync <= '0;
         sleep_sync <= '0;
         psel_sync <= '0;
         comp_sync <= '0;
      end else begin
         tog_sync <= {tog_sync[SYNC_STAGES-1:0], word_toggle};
         reset_sync <= {reset_sync[SYNC_STAGES-2:0], reset_pin};
         sleep_sync <= {sleep_sync[SYNC_STAGES-2:0], sleep_pin};
         psel_sync <= {psel_sync[SYNC_STAGES-2:0], phase_select_pin};
         comp_sync <= {comp_sync[SYNC_STAGES-2:0], comparator_in};
      end
   end

   wire word_stb = tog_sync[SYNC_STAGES] ^ tog_sync[SYNC_STAGES-1];
   wire [1:0] word_dest = word_hold[dds_ctrl_pkg::DEST_HI:dds_ctrl_pkg::DEST_LO];

   // ---------------- Command decode ----------------
   logic [WB-1:0] control;
   logic [PB-1:0] phase_offset_zero;
   logic [PB-1:0] phase_offset_one;

   wire control_wr = word_stb && word_dest == dds_ctrl_pkg::DEST_CONTROL; // see R22
   wire phase_wr = word_stb && word_dest == dds_ctrl_pkg::DEST_PHASE; // see R1
   wire phase_wr_one = phase_wr && word_hold[dds_ctrl_pkg::PHASE_SEL_POS]; // see R2
   wire phase_wr_zero = phase_wr && !word_hold[dds_ctrl_pkg::PHASE_SEL_POS]; // see R2

   // Registers stay writable in sleep and reset alike
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         control <= dds_ctrl_pkg::CONTROL_RESET_VALUE;
         phase_offset_zero <= dds_ctrl_pkg::PHASE_RESET_VALUE;
         phase_offset_one <= dds_ctrl_pkg::PHASE_RESET_VALUE;
      end else begin
         if (control_wr) begin
            control <= word_hold; // see R11
         end
         if (phase_wr_zero) begin
            phase_offset_zero <= word_hold[PB-1:0]; // see R1
         end
         if (phase_wr_one) begin
            phase_offset_one <= word_hold[PB-1:0]; // see R1
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         freq_load <= 1'b0;
         freq_load_one <= 1'b0;
         freq_load_data <= '0;
      end else begin
         freq_load <= word_stb && (word_dest == dds_ctrl_pkg::DEST_FREQ_ZERO
                                   || word_dest == dds_ctrl_pkg::DEST_FREQ_ONE); // see R22
         freq_load_one <= word_dest == dds_ctrl_pkg::DEST_FREQ_ONE;
         freq_load_data <= word_hold[13:0];
      end
   end

   // ---------------- Control fields ----------------
   wire pin_or_software_select = control[dds_ctrl_pkg::CTL_PIN_OR_SOFTWARE];
   wire reset_bit = control[dds_ctrl_pkg::CTL_RESET];
   wire core_clock_disable_bit = control[dds_ctrl_pkg::CTL_CLOCK_DISABLE];
   wire dac_powerdown_bit = control[dds_ctrl_pkg::CTL_DAC_POWERDOWN];
   wire square_output_enable = control[dds_ctrl_pkg::CTL_SQUARE_ENABLE];
   wire comparator_or_msb_select = control[dds_ctrl_pkg::CTL_COMPARATOR_SEL];
   wire msb_direct_not_halved = control[dds_ctrl_pkg::CTL_MSB_DIRECT];
   wire mode_triangle = control[dds_ctrl_pkg::CTL_MODE];
   wire phase_sel_bit = control[dds_ctrl_pkg::CTL_PHASE_SEL];

   // Raw pin ORed in so assertion is not delayed; release waits for the sync
   wire reset_pin_level = reset_pin | reset_sync[SYNC_STAGES-1]; // see R6
   wire sleep_pin_level = sleep_pin | sleep_sync[SYNC_STAGES-1]; // see R12
   wire core_reset = pin_or_software_select ? reset_pin_level : reset_bit; // see R4
   wire clock_halt = !pin_or_software_select && core_clock_disable_bit; // see R9
   wire phase_select = pin_or_software_select ? psel_sync[SYNC_STAGES-1] : phase_sel_bit; // see R11

   assign dac_powerdown = pin_or_software_select ? sleep_pin_level : dac_powerdown_bit; // see R8
   assign core_clock_halted = clock_halt; // see R9

   // ---------------- Phase accumulator and amplitude ----------------
   logic [AB-1:0] acc;
   logic [2:0] start_count;
   logic [DB-1:0] sample;

   wire [AB-1:0] next_acc = acc + freq_word;
   wire [PB-1:0] offset_sel = phase_select ? phase_offset_one : phase_offset_zero;
   wire [PB-1:0] phase = acc[AB-1:AB-PB] + offset_sel; // see R21
   wire [DB-1:0] next_sample = mode_triangle ? triangle_amp(phase) : sine_amp(phase); // see R17
   wire started = start_count == dds_ctrl_pkg::START_LATENCY;

   always_ff @(posedge clk_sys) begin
      if (srst || core_reset) begin
         acc <= '0; // see R3
      end else if (!clock_halt) begin
         acc <= next_acc; // see R10
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || core_reset) begin
         start_count <= 3'h0; // see R5
      end else if (!started && !clock_halt) begin
         start_count <= start_count + 3'h1; // see R5
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || core_reset) begin
         sample <= dds_ctrl_pkg::DAC_MIDSCALE; // see R3
      end else if (!clock_halt) begin
         sample <= started ? next_sample : dds_ctrl_pkg::DAC_MIDSCALE; // see R5
      end
   end

   // Pin reset forces midscale at once, ahead of the clocked path
   assign dac_data = (pin_or_software_select && reset_pin) ? dds_ctrl_pkg::DAC_MIDSCALE : sample; // see R6

   // ---------------- Square output ----------------
   logic msb_prev;
   logic msb_half;
   wire dac_msb = sample[DB-1];

   always_ff @(posedge clk_sys) begin
      if (srst || core_reset) begin
         // Midscale MSB is one; a zero here would fake an edge at release
         msb_prev <= dds_ctrl_pkg::DAC_MIDSCALE[DB-1];
         msb_half <= 1'b0;
      end else begin
         msb_prev <= dac_msb;
         if (dac_msb && !msb_prev) begin
            msb_half <= ~msb_half; // see R15
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         square_out <= 1'b0;
      end else if (comparator_or_msb_select) begin
         square_out <= comp_sync[SYNC_STAGES-1]; // see R14
      end else begin
         square_out <= msb_direct_not_halved ? dac_msb : msb_half; // see R15
      end
   end

   assign square_out_oe = square_output_enable; // see R13

   // ---------------- Assertions ----------------
   property p_phase_zero_load;
      @(posedge clk_sys) disable iff (srst)
         phase_wr_zero |=> phase_offset_zero == $past(word_hold[PB-1:0]) && $stable(phase_offset_one);
   endproperty
   a_phase_zero_load: assert property (p_phase_zero_load) else $error("phase zero load wrong"); // see R1

   property p_phase_one_load;
      @(posedge clk_sys) disable iff (srst)
         word_stb && word_dest == dds_ctrl_pkg::DEST_PHASE && word_hold[dds_ctrl_pkg::PHASE_SEL_POS]
            |=> phase_offset_one == $past(word_hold[PB-1:0]);
   endproperty
   a_phase_one_load: assert property (p_phase_one_load) else $error("phase one load wrong"); // see R2

   property p_reset_clears;
      @(posedge clk_sys) disable iff (srst)
         core_reset && !phase_wr_zero
            |=> acc == '0 && sample == dds_ctrl_pkg::DAC_MIDSCALE && $stable(phase_offset_zero);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear core"); // see R3

   property p_reset_source;
      @(posedge clk_sys) disable iff (srst)
         !control[dds_ctrl_pkg::CTL_PIN_OR_SOFTWARE] |-> core_reset == control[dds_ctrl_pkg::CTL_RESET];
   endproperty
   a_reset_source: assert property (p_reset_source) else $error("reset source wrong"); // see R4

   property p_start_latency;
      @(posedge clk_sys) disable iff (srst)
         $fell(core_reset) && !clock_halt ##0 (!core_reset && !clock_halt)[*7] |=> started;
   endproperty
   a_start_latency: assert property (p_start_latency) else $error("first sample latency wrong"); // see R5

   property p_not_started_early;
      @(posedge clk_sys) disable iff (srst)
         $fell(core_reset) |-> !started ##1 !started;
   endproperty
   a_not_started_early: assert property (p_not_started_early) else $error("sample released too soon"); // see R5

   property p_halt_freezes;
      @(posedge clk_sys) disable iff (srst)
         clock_halt && !core_reset ##1 clock_halt && !core_reset |-> $stable(acc) && $stable(sample);
   endproperty
   a_halt_freezes: assert property (p_halt_freezes) else $error("accumulator moved while halted"); // see R10

   property p_sleep_pin;
      @(posedge clk_sys) disable iff (srst)
         control[9] && sleep_pin |-> dac_powerdown && !core_clock_halted;
   endproperty
   a_sleep_pin: assert property (p_sleep_pin) else $error("sleep pin not immediate"); // see R8

   property p_square_msb;
      @(posedge clk_sys) disable iff (srst)
         !comparator_or_msb_select && msb_direct_not_halved |=> square_out == $past(dac_msb);
   endproperty
   a_square_msb: assert property (p_square_msb) else $error("square output source wrong"); // see R14

   property p_oe_load;
      @(posedge clk_sys) disable iff (srst)
         control_wr |=> square_out_oe == $past(word_hold[dds_ctrl_pkg::CTL_SQUARE_ENABLE]);
   endproperty
   a_oe_load: assert property (p_oe_load) else $error("square output enable not loaded"); // see R13

   property p_reset_release;
      @(posedge clk_sys) disable iff (srst)
         pin_or_software_select && $fell(reset_pin) ##1 pin_or_software_select |-> core_reset;
   endproperty
   a_reset_release: assert property (p_reset_release) else $error("reset pin release not synchronised"); // see R6

   property p_sleep_release;
      @(posedge clk_sys) disable iff (srst)
         pin_or_software_select && $fell(sleep_pin) ##1 pin_or_software_select |-> dac_powerdown;
   endproperty
   a_sleep_release: assert property (p_sleep_release) else $error("sleep pin release not synchronised"); // see R12

   property p_freq_one_load;
      @(posedge clk_sys) disable iff (srst)
         word_stb && word_dest == dds_ctrl_pkg::DEST_FREQ_ONE |=> freq_load && freq_load_one;
   endproperty
   a_freq_one_load: assert property (p_freq_one_load) else $error("frequency load not flagged"); // see R22

endmodule

// ==== dds_host_model.sv ====
module dds_host_model (
   // Serial link toward the device
   output logic sclk,
   output logic sdata,
   output logic word_frame_strobe_n
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      word_frame_strobe_n = 1'b1;
   end

   // Serial clock stands still outside frames, 32 ns period inside
   task automatic send_word(input logic [15:0] w);
      #0.7;
      word_frame_strobe_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdata = w[i];
         #8 sclk = 1'b1;
         #16 sclk = 1'b0;
         #8;
      end
      word_frame_strobe_n = 1'b1;
      // Released line shows the inverse so stale data cannot pass
      sdata = ~sdata;
      #40;
   endtask
endmodule

// ==== dds_phase_reset_sleep_output_ctrl_bench.sv ====
module dds_phase_reset_sleep_output_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_sys, srst, sclk, sdata, word_frame_strobe_n;
   logic reset_pin, sleep_pin, phase_select_pin, comparator_in;
   logic [27:0] freq_word;
   logic freq_load, freq_load_one, dac_powerdown, core_clock_halted, square_out, square_out_oe;
   logic [13:0] freq_load_data;
   logic [9:0] dac_data;
   logic [9:0] held;
   logic [14:0] exp_q[$];
   int n_mismatch = 0;
   int tests_run = 0;

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   dds_phase_reset_sleep_output_ctrl #(.SYNC_STAGES(2)) dut_u (
      .clk_sys(clk_sys), .srst(srst), .sclk(sclk), .sdata(sdata),
      .word_frame_strobe_n(word_frame_strobe_n), .reset_pin(reset_pin), .sleep_pin(sleep_pin),
      .phase_select_pin(phase_select_pin), .comparator_in(comparator_in), .freq_word(freq_word),
      .freq_load(freq_load), .freq_load_one(freq_load_one), .freq_load_data(freq_load_data),
      .dac_data(dac_data), .dac_powerdown(dac_powerdown), .core_clock_halted(core_clock_halted),
      .square_out(square_out), .square_out_oe(square_out_oe));

   dds_host_model host_u (.sclk(sclk), .sdata(sdata), .word_frame_strobe_n(word_frame_strobe_n));

   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task summarize;
      $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task word(input logic [15:0] w);
      host_u.send_word(w);
      cyc(10);
   endtask

   // Window is a whole number of output periods, so rise counts are exact
   task count_rises(input logic [15:0] sq_want);
      logic [15:0] n_msb, n_sq;
      logic msb_last, sq_last;
      n_msb = 16'h0;
      n_sq = 16'h0;
      cyc(1);
      msb_last = dac_data[9];
      sq_last = square_out;
      repeat (1024) begin
         cyc(1);
         if (dac_data[9] && !msb_last) n_msb++;
         if (square_out && !sq_last) n_sq++;
         msb_last = dac_data[9];
         sq_last = square_out;
      end
      check("msb_rises", n_msb, 16'h4);
      check("square_rises", n_sq, sq_want);
   endtask

   task freq(input logic one);
      logic [13:0] d;
      d = 14'($urandom());
      exp_q.push_back({one, d});
      word({one, ~one, d});
   endtask

   // Every frequency load pulse is matched against the oldest note
   always @(posedge clk_sys) begin
      if (freq_load === 1'b1) begin
         if (exp_q.size() == 0) check("freq_load_extra", 16'h1, 16'h0);
         else check("freq_load", {1'b0, freq_load_one, freq_load_data}, {1'b0, exp_q.pop_front()});
      end
   end

   initial begin
      #100us;
      n_mismatch++;
      $display("Watchdog expired");
      summarize();
   end

   initial begin
      // Rising edge needed so the link toggle is cleared
      srst = 1'b0;
      #1;
      srst = 1'b1;
      reset_pin = 1'b0;
      sleep_pin = 1'b0;
      phase_select_pin = 1'b0;
      comparator_in = 1'b0;
      freq_word = 28'h0000000;
      void'($urandom(32'h145514ae));
      cyc(20);
      check("dac_rst", {6'h0, dac_data}, 16'h0200);
      check("oe_rst", {15'h0, square_out_oe}, 16'h0);
      check("pd_rst", {15'h0, dac_powerdown}, 16'h0);
      srst <= 1'b0;
      cyc(4);
      freq_word <= {8'h01, 20'($urandom())};
      for (int i = 0; i < 4; i++) freq(i[0]);
      // Comparator source, direct, mode zero
      word(16'h0038);
      check("oe_on", {15'h0, square_out_oe}, 16'h1);
      for (int i = 0; i < 2; i++) begin
         comparator_in <= i[0];
         cyc(5);
         check("square_cmp", {15'h0, square_out}, {15'h0, i[0]});
      end
      word(16'h0000);
      check("oe_off", {15'h0, square_out_oe}, 16'h0);
      for (int i = 0; i < 4; i++) begin
         word(16'(i << 6));
         check("halted", {15'h0, core_clock_halted}, {15'h0, i[1]});
         check("pd_bit", {15'h0, dac_powerdown}, {15'h0, i[0]});
      end
      // Triangle running, then frozen by the clock-disable bit
      word(16'h0002);
      word(16'h0082);
      held = dac_data;
      cyc(20);
      check("frozen", {6'h0, dac_data}, {6'h0, held});
      freq(1'b0);
      word(16'h0002);
      check("resumed", {15'h0, dac_data !== held}, 16'h1);
      // Pin mode: bits ignored, sleep pin governs
      word(16'h02c0);
      check("halted_pin", {15'h0, core_clock_halted}, 16'h0);
      check("pd_pin0", {15'h0, dac_powerdown}, 16'h0);
      sleep_pin <= 1'b1;
      @(posedge clk_sys);
      #1 check("pd_now", {15'h0, dac_powerdown}, 16'h1);
      sleep_pin <= 1'b0;
      @(posedge clk_sys);
      #1 check("pd_hold", {15'h0, dac_powerdown}, 16'h1);
      cyc(4);
      check("pd_rel", {15'h0, dac_powerdown}, 16'h0);
      // Pin mode with the reset bit set: pin governs, so output runs
      word(16'h0302);
      held = dac_data;
      cyc(3);
      check("bit_ignored", {15'h0, dac_data !== held}, 16'h1);
      word(16'hd200);
      word(16'hea00);
      reset_pin <= 1'b1;
      @(posedge clk_sys);
      #1 check("pin_rst_now", {6'h0, dac_data}, 16'h0200);
      cyc(3);
      reset_pin <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         cyc(1);
         check("start_wait", {6'h0, dac_data}, 16'h0200);
      end
      cyc(1);
      check("started", {15'h0, dac_data !== 10'h200}, 16'h1);
      // Fixed phase: offsets survive a core reset and pick the sample
      freq_word <= 28'h0000000;
      reset_pin <= 1'b1;
      cyc(2);
      reset_pin <= 1'b0;
      cyc(14);
      check("phase_zero", {6'h0, dac_data}, 16'h0100);
      phase_select_pin <= 1'b1;
      cyc(8);
      check("phase_one", {6'h0, dac_data}, 16'h02ff);
      word(16'h0102);
      check("bit_reset", {6'h0, dac_data}, 16'h0200);
      // Sine, one output period per 256 cycles: MSB direct, then halved
      freq_word <= 28'h0100000;
      word(16'h0028);
      count_rises(16'h4);
      word(16'h0020);
      count_rises(16'h2);
      check("freq_pending", 16'(exp_q.size()), 16'h0);
      cyc(4);
      summarize();
   end
endmodule
